// File: logic/asram_host.sv
`timescale 1ns/1ps
module asram_host (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Request side
  input wire asram_pkg::asram_req_type i_req,
  output logic o_ready,
  output asram_pkg::asram_rsp_type o_rsp,
  // Memory pins
  output logic [asram_pkg::ADDR_W-1:0] o_word_address_in,
  output logic o_select_n,
  output logic o_write_n,
  output logic o_gate_n,
  output logic [asram_pkg::DATA_W-1:0] o_shared_data_lines,
  output logic o_shared_data_lines_oe,
  input wire logic [asram_pkg::DATA_W-1:0] i_shared_data_lines
);

  typedef struct packed {
    asram_pkg::asram_state_type state;
    asram_pkg::asram_pins_type pins;
    logic ready;
    asram_pkg::asram_rsp_type rsp;
  } asram_host_st_type;

  asram_host_st_type st_r;
  asram_host_st_type st_nxt;
  logic tick_load;
  logic [3:0] tick_count;
  logic tick_done;

  function automatic asram_pkg::asram_pins_type asram_idle_pins(input logic [asram_pkg::ADDR_W-1:0] a);
    asram_pkg::asram_pins_type p;
    p.addr = a;
    p.select_n = 1'b1;
    p.write_n = 1'b1;
    p.gate_n = 1'b1;
    p.dout = asram_pkg::DATA_RST;
    p.dout_oe = 1'b0;
    return p;
  endfunction : asram_idle_pins

  asram_tick u_tick (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_load(tick_load),
    .i_count(tick_count),
    .o_expired(tick_done)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp.done = 1'b0;
    tick_load = 1'b0;
    tick_count = 4'h0;
    case (st_r.state)
      asram_pkg::ST_IDLE: begin
        st_nxt.pins = asram_idle_pins(st_r.pins.addr);
        if (st_r.ready && i_req.valid) begin
          st_nxt.ready = 1'b0;
          // Address placed one cycle before select falls
          st_nxt.pins.addr = i_req.addr;
          if (i_req.write) begin
            st_nxt.pins.dout = i_req.wdata;
            st_nxt.state = asram_pkg::ST_WR_SETUP;
          end else begin
            st_nxt.state = asram_pkg::ST_RD_SETUP;
          end
        end
      end
      asram_pkg::ST_RD_SETUP: begin
        // Strobe stays high through the read, data lines released
        st_nxt.pins.select_n = 1'b0;
        st_nxt.pins.gate_n = 1'b0;
        st_nxt.pins.write_n = 1'b1;
        st_nxt.pins.dout_oe = 1'b0;
        tick_load = 1'b1;
        tick_count = asram_pkg::RD_WAIT_CYC;
        st_nxt.state = asram_pkg::ST_RD_WAIT;
      end
      asram_pkg::ST_RD_WAIT: begin
        if (tick_done) begin
          st_nxt.rsp.rdata = i_shared_data_lines;
          st_nxt.rsp.done = 1'b1;
          st_nxt.pins = asram_idle_pins(st_r.pins.addr);
          st_nxt.state = asram_pkg::ST_TURN;
        end
      end
      asram_pkg::ST_WR_SETUP: begin
        // Select, strobe and data start together; gate stays high, but the strobe is still timed to the longer gate-low minimum
        st_nxt.pins.select_n = 1'b0;
        st_nxt.pins.dout_oe = 1'b1;
        st_nxt.pins.gate_n = 1'b1;
        st_nxt.pins.write_n = 1'b0;
        tick_load = 1'b1;
        tick_count = asram_pkg::WR_LOW_CYC;
        st_nxt.state = asram_pkg::ST_WR_PULSE;
      end
      asram_pkg::ST_WR_PULSE: begin
        if (tick_done) begin
          // Strobe rises first; select, address and data held one more cycle
          st_nxt.pins.write_n = 1'b1;
          st_nxt.state = asram_pkg::ST_WR_RECOVER;
        end
      end
      asram_pkg::ST_WR_RECOVER: begin
        st_nxt.pins = asram_idle_pins(st_r.pins.addr);
        st_nxt.rsp.done = 1'b1;
        st_nxt.state = asram_pkg::ST_TURN;
      end
      asram_pkg::ST_TURN: begin
        // Idle cycle lets the memory float before anyone drives again
        st_nxt.ready = 1'b1;
        st_nxt.state = asram_pkg::ST_IDLE;
      end
      default: begin
        st_nxt.pins = asram_idle_pins(asram_pkg::ADDR_RST);
        st_nxt.ready = 1'b0;
        st_nxt.state = asram_pkg::ST_TURN;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_r.state <= asram_pkg::ST_TURN;
      st_r.pins <= {asram_pkg::ADDR_RST, 3'b111, asram_pkg::DATA_RST, 1'b0};
      st_r.ready <= 1'b0;
      st_r.rsp <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_ready = st_r.ready;
  assign o_rsp = st_r.rsp;
  assign o_word_address_in = st_r.pins.addr;
  assign o_select_n = st_r.pins.select_n;
  assign o_write_n = st_r.pins.write_n;
  assign o_gate_n = st_r.pins.gate_n;
  assign o_shared_data_lines = st_r.pins.dout;
  assign o_shared_data_lines_oe = st_r.pins.dout_oe;

  sequence seq_wr_start;
    $fell(o_write_n) && !o_select_n && o_shared_data_lines_oe;
  endsequence

  sequence seq_wr_low;
    (!o_write_n && !o_select_n && o_shared_data_lines_oe && $stable(o_word_address_in)) [*1];
  endsequence

  AST_NO_DRIVE_IN_READ: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !o_gate_n |-> !o_shared_data_lines_oe)
    else $error("data driven while gate low");

  AST_WE_HIGH_IN_READ: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !o_gate_n |-> o_write_n)
    else $error("write strobe low during read");

  AST_WRITE_PULSE_LEN: assert property (@(posedge i_core_clk) disable iff (i_srst)
    seq_wr_start |-> seq_wr_low ##1 o_write_n)
    else $error("write interval length wrong");

  AST_SELECT_BEFORE_WE: assert property (@(posedge i_core_clk) disable iff (i_srst)
    $rose(o_write_n) |-> $past(!o_select_n) && !o_select_n)
    else $error("select not held through write");

  AST_ADDR_BEFORE_SELECT: assert property (@(posedge i_core_clk) disable iff (i_srst)
    $fell(o_select_n) |-> $stable(o_word_address_in))
    else $error("address changed with select");

  AST_WE_ENDS_FIRST: assert property (@(posedge i_core_clk) disable iff (i_srst)
    $rose(o_write_n) |-> !o_select_n && o_shared_data_lines_oe ##1 o_select_n)
    else $error("write end ordering wrong");

  AST_DATA_HELD: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !o_write_n |-> $stable(o_shared_data_lines))
    else $error("write data changed in interval");

  AST_READ_DONE: assert property (@(posedge i_core_clk) disable iff (i_srst)
    $fell(o_gate_n) |-> ##1 !o_gate_n ##1 (o_gate_n && o_rsp.done))
    else $error("read length wrong");

  AST_WRITE_DONE: assert property (@(posedge i_core_clk) disable iff (i_srst)
    $rose(o_write_n) |-> ##1 o_rsp.done)
    else $error("write done missing");

  AST_ADDR_HELD_SELECTED: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !o_select_n |-> $stable(o_word_address_in))
    else $error("address changed while selected");

  AST_GATE_HIGH_IN_WRITE: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !o_write_n |-> o_gate_n)
    else $error("gate low during write");

  AST_DRIVE_ONLY_SELECTED: assert property (@(posedge i_core_clk) disable iff (i_srst)
    o_shared_data_lines_oe |-> !o_select_n && o_gate_n)
    else $error("data driven outside write");

endmodule : asram_host

// File: logic/asram_pkg.sv
package asram_pkg;

  // Memory geometry
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned WORDS = 32768;

  // Core clock period in picoseconds (40 MHz)
  localparam int unsigned CLK_PERIOD_PS = 25000;

  // Speed grade timing in ns (slowest grade of 15/17/20 used as default)
  localparam int unsigned WRITE_INTERVAL_MIN_GATE_HIGH_NS = 13;
  localparam int unsigned WRITE_INTERVAL_MIN_GATE_LOW_NS = 20;
  localparam int unsigned SELECT_TO_WRITE_END_MIN_NS = 13;
  localparam int unsigned ADDRESS_TO_WRITE_END_MIN_NS = 13;
  localparam int unsigned DATA_BEFORE_WRITE_END_MIN_NS = 10;
  localparam int unsigned GATE_TO_READ_VALID_MAX_NS = 10;

  function automatic int unsigned asram_min_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : asram_min_cycles

  // Write strobe low time: longest of all write minima, the gate-low figure, although gate is held high during writes
  localparam int unsigned WR_LOW_CYC_RAW = asram_min_cycles(WRITE_INTERVAL_MIN_GATE_LOW_NS);
  localparam int unsigned WR_SEL_CYC = asram_min_cycles(SELECT_TO_WRITE_END_MIN_NS);
  localparam int unsigned WR_ADR_CYC = asram_min_cycles(ADDRESS_TO_WRITE_END_MIN_NS);
  localparam int unsigned WR_DAT_CYC = asram_min_cycles(DATA_BEFORE_WRITE_END_MIN_NS);
  localparam int unsigned RD_GATE_CYC_RAW = asram_min_cycles(GATE_TO_READ_VALID_MAX_NS);
  // One extra cycle for the sampling edge on top of the access time
  localparam logic [3:0] WR_LOW_CYC = 4'(WR_LOW_CYC_RAW);
  localparam logic [3:0] RD_WAIT_CYC = 4'(RD_GATE_CYC_RAW + 1);

  // Bus-idle levels
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic select_n;
    logic write_n;
    logic gate_n;
    logic [DATA_W-1:0] dout;
    logic dout_oe;
  } asram_pins_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asram_req_type;

  typedef struct packed {
    logic done;
    logic [DATA_W-1:0] rdata;
  } asram_rsp_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_SETUP,
    ST_RD_WAIT,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_RECOVER,
    ST_TURN
  } asram_state_type;

endpackage : asram_pkg

// File: logic/asram_tick.sv
`timescale 1ns/1ps
module asram_tick (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Control
  input wire logic i_load,
  input wire logic [3:0] i_count,
  // Status
  output logic o_expired
);

  typedef struct packed {
    logic [3:0] cnt;
  } asram_tick_st_type;

  asram_tick_st_type st_r;
  asram_tick_st_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (i_load) begin
      st_nxt.cnt = i_count;
    end else if (st_r.cnt != 4'h0) begin
      st_nxt.cnt = st_r.cnt - 4'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_expired = (st_r.cnt == 4'h1) && !i_load;

endmodule : asram_tick

// File: dv/asram_mem_model.sv
`timescale 1ns/1ps
module asram_mem_model #(
  parameter int ACCESS_NS = 10
) (
  // Memory pins
  input wire logic [14:0] i_addr,
  input wire logic i_select_n,
  input wire logic i_write_n,
  input wire logic i_gate_n,
  input wire logic [7:0] i_data,
  // Driven data
  output logic [7:0] o_data,
  output logic o_oe
);
  logic [7:0] mem [0:32767];
  logic [7:0] last;
  wire wr_on = ~i_select_n & ~i_write_n;
  wire rd_on = ~i_select_n & ~i_gate_n & i_write_n;
  always @(negedge wr_on) mem[i_addr] = i_data;
  always @* if (rd_on) last = mem[i_addr];
  // Floating lines show inverted data so a stale value never passes
  assign #(ACCESS_NS) o_data = rd_on ? mem[i_addr] : ~last;
  assign #(ACCESS_NS) o_oe = rd_on;
endmodule : asram_mem_model

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk;
  logic i_srst;
  asram_pkg::asram_req_type req;
  asram_pkg::asram_rsp_type rsp;
  logic ready, sel_n, wr_n, gate_n, h_oe, m_oe, prev_sel;
  logic [14:0] addr, prev_addr;
  logic [7:0] h_dat, m_dat, q, prev_dat;
  wire [7:0] bus = h_oe ? h_dat : m_dat;
  int err_count, checked, wcnt;

  asram_host u_dut (.i_core_clk(clk), .i_srst(i_srst), .i_req(req), .o_ready(ready), .o_rsp(rsp),
    .o_word_address_in(addr), .o_select_n(sel_n), .o_write_n(wr_n), .o_gate_n(gate_n),
    .o_shared_data_lines(h_dat), .o_shared_data_lines_oe(h_oe), .i_shared_data_lines(bus));
  asram_mem_model #(.ACCESS_NS(10)) u_mem (.i_addr(addr), .i_select_n(sel_n), .i_write_n(wr_n),
    .i_gate_n(gate_n), .i_data(bus), .o_data(m_dat), .o_oe(m_oe));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // Pin monitor; write length in cycles times the period must cover the minimum
  always @(posedge clk) begin
    if (i_srst) wcnt = 0;
    else begin
      check("contention", h_oe & m_oe, 1'b0);
      if (!sel_n && !gate_n) check("strobe_in_read", wr_n, 1'b1);
      if (!sel_n && !prev_sel) check("addr_hold", addr, prev_addr);
      if (!sel_n && !wr_n) begin
        wcnt++;
        check("gate_in_write", gate_n, 1'b1);
        check("data_driven", h_oe, 1'b1);
        check("data_hold", h_dat, prev_dat);
      end else if (wcnt != 0) begin
        check("write_len", (wcnt * 25 >= asram_pkg::WRITE_INTERVAL_MIN_GATE_HIGH_NS), 1'b1);
        wcnt = 0;
      end
    end
    prev_sel = sel_n;
    prev_addr = addr;
    prev_dat = h_dat;
  end

  task automatic do_req(input logic wr, input logic [14:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    check("ready", ready, 1'b1);
    req = '{1'b1, wr, a, d};
    @(negedge clk);
    req.valid = 1'b0;
    n = 0;
    while (rsp.done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check("done", rsp.done, 1'b1);
    q = rsp.rdata;
  endtask : do_req

  task automatic t_table;
    logic [14:0] at [3] = '{15'h0000, 15'h7FFF, 15'h1234};
    logic [7:0] dt [3] = '{8'h55, 8'hAA, 8'hC3};
    foreach (at[i]) do_req(1'b1, at[i], dt[i]);
    foreach (at[i]) begin
      do_req(1'b0, at[i], 8'h00);
      check("read_back", q, dt[i]);
    end
    $display("Test table done");
  endtask : t_table

  task automatic t_refused;
    do_req(1'b1, 15'h0042, 8'h33);
    do_req(1'b1, 15'h0041, 8'h5A);
    req = '{1'b1, 1'b1, 15'h0042, 8'h66};
    check("busy_ready", ready, 1'b0);
    @(negedge clk);
    req.valid = 1'b0;
    do_req(1'b0, 15'h0042, 8'h00);
    check("refused_req", q, 8'h33);
    do_req(1'b0, 15'h0041, 8'h00);
    check("first_write", q, 8'h5A);
    $display("Test refused done");
  endtask : t_refused

  task automatic t_midreset;
    while (ready !== 1'b1) @(negedge clk);
    req = '{1'b1, 1'b1, 15'h0100, 8'h0F};
    @(negedge clk);
    req.valid = 1'b0;
    repeat (2) @(negedge clk);
    i_srst = 1'b1;
    repeat (2) @(negedge clk);
    check("rst_pins", {sel_n, wr_n, gate_n, h_oe, ready}, 5'h1C);
    i_srst = 1'b0;
    do_req(1'b1, 15'h0100, 8'hF0);
    do_req(1'b0, 15'h0100, 8'h00);
    check("after_reset", q, 8'hF0);
    $display("Test midreset done");
  endtask : t_midreset

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #(25 * 5000);
    err_count++;
    finish_test();
  end

  initial begin
    i_srst = 1'b1;
    req = '0;
    repeat (10) @(negedge clk);
    check("reset_pins", {sel_n, wr_n, gate_n, h_oe, ready}, 5'h1C);
    i_srst = 1'b0;
    $display("Test reset done");
    t_table();
    t_refused();
    t_midreset();
    finish_test();
  end
endmodule : tb_top
